// ### verilog/sfm_mode_ctrl.sv
// Mode control of a serial multi-line flash: command, read and address modes
//
// Function
// - Exit instruction returns the device to single-line command input.
// - Entry instruction switches instruction, address and data to four lines.
// - Mode byte 00h ends continuous read after the current read.
// - All ones on four lines for 8 or 10 clocks forces exit.
// - Mode byte A5h after quad read address enters continuous read.
// - Quad-enable flag sits at status bit 6; one enables four lines.
// - Status register is non-volatile; writing needs prior write enable.
// - Reset-enable immediately followed by reset restores power-on state.
// - Exit instruction leaves four-byte addressing without write enable.
// - Hardware reset returns the device to three-byte addressing.
// - Continuous quad read omits the instruction on following reads.
module sfm_mode_ctrl
    import sfm_pkg::*;
#(
    parameter logic [7:0] OP_ADDR4_ENTER = 8'hb7
)(
    input wire logic mclk,
    input wire logic resetn,
    input wire logic sclk_pin,
    input wire logic cs_n_pin,
    input wire logic [3:0] quad_data_lines,
    input wire logic hw_reset_n_pin,
    input wire logic [7:0] nv_status_init,
    output logic [7:0] status_reg,
    output logic quad_enable_flag,
    output logic quad_cmd_mode,
    output logic cont_read,
    output logic addr4_mode,
    output logic nv_write,
    output logic [7:0] nv_write_data
);
    sfm_link_if lk ();

    sfm_link_rx u_rx (
        .mclk(mclk),
        .resetn(resetn),
        .sclk_pin(sclk_pin),
        .cs_n_pin(cs_n_pin),
        .dq_pin(quad_data_lines),
        .hw_reset_n_pin(hw_reset_n_pin),
        .lk(lk.rx)
    );

    // =========================================================
    // Frame decoder state
    sfm_state_e state, next_state;
    logic [7:0] shreg, next_shreg;
    logic [3:0] bitcnt, next_bitcnt;
    logic [2:0] bytecnt, next_bytecnt;
    logic [7:0] opcode, next_opcode;
    logic [7:0] data, next_data;
    logic clean, next_clean;
    logic have_data, next_have_data;
    logic mode_exit, next_mode_exit;
    logic ones_run, next_ones_run;
    logic [3:0] ones_cnt, next_ones_cnt;
    logic arm, next_arm;
    logic wel, next_wel;
    logic [7:0] sr, next_sr;
    logic sr_loaded, next_sr_loaded;
    logic next_qpi, next_cont, next_addr4, next_nv_write;
    logic quad, byte_done, soft_rst;
    logic [7:0] sh_new;
    logic [3:0] bits_new;
    logic [3:0] exit_len;
    logic [2:0] addr_bytes;

    function automatic logic [7:0] shift_in(input logic [7:0] s,
                                            input logic [3:0] d,
                                            input logic four);
        shift_in = four ? {s[3:0], d} : {s[6:0], d[0]};
    endfunction

    assign quad_enable_flag = sr[QE_BIT];
    assign status_reg = {sr[7:2], wel, sr[0]};
    assign exit_len = addr4_mode ? ONES_EXIT_4B : ONES_EXIT_3B;
    assign addr_bytes = addr4_mode ? ADDR_BYTES_4B : ADDR_BYTES_3B;
    // Address and mode phases of a quad read always use all four lines
    assign quad = quad_cmd_mode || state == ST_ADDR || state == ST_MODE;
    assign sh_new = shift_in(shreg, lk.dq, quad);
    assign bits_new = bitcnt + (quad ? 4'h4 : 4'h1);
    assign byte_done = bits_new == BITS_PER_BYTE;

    always_comb begin
        next_state = state;
        next_shreg = shreg;
        next_bitcnt = bitcnt;
        next_bytecnt = bytecnt;
        next_opcode = opcode;
        next_data = data;
        next_clean = clean;
        next_have_data = have_data;
        next_mode_exit = mode_exit;
        next_ones_run = ones_run;
        next_ones_cnt = ones_cnt;
        next_arm = arm;
        next_wel = wel;
        next_sr = sr;
        next_sr_loaded = 1'b1;
        next_qpi = quad_cmd_mode;
        next_cont = cont_read;
        next_addr4 = addr4_mode;
        next_nv_write = 1'b0;
        soft_rst = 1'b0;
        // Stored status comes back as last written, once after power-on
        if (!sr_loaded) begin
            next_sr = nv_status_init;
        end
        if (lk.hw_reset) begin
            next_state = ST_IDLE;
            next_qpi = 1'b0;
            next_cont = 1'b0;
            next_addr4 = 1'b0;
            next_wel = 1'b0;
            next_arm = 1'b0;
        end else if (lk.cs_fall) begin
            // Continuous read frames start straight with the address
            next_state = cont_read ? ST_ADDR : ST_OPCODE;
            next_bitcnt = 4'h0;
            next_bytecnt = 3'h0;
            next_opcode = 8'h00;
            next_clean = 1'b0;
            next_have_data = 1'b0;
            next_mode_exit = 1'b0;
            next_ones_cnt = 4'h0;
            next_ones_run = cont_read;
        end else if (lk.sclk_rise && lk.cs_active && state != ST_IDLE) begin
            next_shreg = sh_new;
            next_bitcnt = byte_done ? 4'h0 : bits_new;
            unique case (state)
                ST_OPCODE: begin
                    if (byte_done) begin
                        next_opcode = sh_new;
                        next_clean = 1'b1;
                        next_state = ST_SKIP;
                        if (sh_new == OP_QUAD_READ &&
                            (sr[QE_BIT] || quad_cmd_mode)) begin
                            next_clean = 1'b0;
                            next_state = ST_ADDR;
                        end else if (sh_new == OP_WRSR) begin
                            next_clean = 1'b0;
                            next_state = ST_DATA;
                        end
                    end
                end
                ST_ADDR: begin
                    if (byte_done) begin
                        next_bytecnt = bytecnt + 3'h1;
                        if (bytecnt == addr_bytes - 3'h1) begin
                            next_state = ST_MODE;
                        end
                    end
                end
                ST_MODE: begin
                    if (byte_done) begin
                        next_state = ST_SKIP;
                        if (sh_new == MODE_CONT_ENTER) begin
                            next_cont = 1'b1;
                        end else begin
                            // Any other byte, 00h among them
                            next_mode_exit = 1'b1;
                        end
                    end
                end
                ST_DATA: begin
                    if (byte_done) begin
                        next_data = sh_new;
                        next_have_data = 1'b1;
                        next_clean = 1'b1;
                        next_state = ST_SKIP;
                    end
                end
                ST_SKIP: begin
                    // Extra clocks spoil a command frame
                    next_clean = 1'b0;
                end
                ST_IDLE: begin
                end
            endcase
            if (ones_run) begin
                if (lk.dq == LANES_ALL_ONES) begin
                    next_ones_cnt = ones_cnt + 4'h1;
                    if (ones_cnt + 4'h1 == exit_len) begin
                        next_cont = 1'b0;
                        next_ones_run = 1'b0;
                        next_state = ST_SKIP;
                        next_clean = 1'b0;
                    end
                end else begin
                    next_ones_run = 1'b0;
                end
            end
        end else if (lk.cs_rise) begin
            next_state = ST_IDLE;
            next_arm = clean && opcode == OP_RST_ENABLE;
            if (mode_exit) begin
                next_cont = 1'b0;
            end
            if (clean) begin
                unique case (opcode)
                    OP_WREN: next_wel = 1'b1;
                    OP_QPI_ENTER: next_qpi = 1'b1;
                    OP_QPI_EXIT: next_qpi = 1'b0;
                    OP_ADDR4_EXIT: next_addr4 = 1'b0;
                    OP_RST: soft_rst = arm;
                    OP_WRSR: begin
                        if (have_data && wel) begin
                            next_sr = data;
                            next_wel = 1'b0;
                            next_nv_write = 1'b1;
                        end
                    end
                    default: begin
                        if (opcode == OP_ADDR4_ENTER) begin
                            next_addr4 = 1'b1;
                        end
                    end
                endcase
            end
            if (soft_rst) begin
                next_qpi = 1'b0;
                next_cont = 1'b0;
                next_addr4 = 1'b0;
                next_wel = 1'b0;
            end
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            state <= ST_IDLE;
            shreg <= 8'h00;
            bitcnt <= 4'h0;
            bytecnt <= 3'h0;
            opcode <= 8'h00;
            data <= 8'h00;
            clean <= 1'b0;
            have_data <= 1'b0;
            mode_exit <= 1'b0;
            ones_run <= 1'b0;
            ones_cnt <= 4'h0;
            arm <= 1'b0;
            wel <= 1'b0;
            sr <= SR_RESET;
            sr_loaded <= 1'b0;
            quad_cmd_mode <= 1'b0;
            cont_read <= 1'b0;
            addr4_mode <= 1'b0;
            nv_write <= 1'b0;
            nv_write_data <= 8'h00;
        end else begin
            state <= next_state;
            shreg <= next_shreg;
            bitcnt <= next_bitcnt;
            bytecnt <= next_bytecnt;
            opcode <= next_opcode;
            data <= next_data;
            clean <= next_clean;
            have_data <= next_have_data;
            mode_exit <= next_mode_exit;
            ones_run <= next_ones_run;
            ones_cnt <= next_ones_cnt;
            arm <= next_arm;
            wel <= next_wel;
            sr <= next_sr;
            sr_loaded <= next_sr_loaded;
            quad_cmd_mode <= next_qpi;
            cont_read <= next_cont;
            addr4_mode <= next_addr4;
            nv_write <= next_nv_write;
            nv_write_data <= next_sr;
        end
    end

    // =========================================================
    // Checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    AST_QPI_EXIT: assert property (
        lk.cs_rise && clean && opcode == OP_QPI_EXIT && !lk.hw_reset
        |=> !quad_cmd_mode) else $error("four-line mode not left");
    AST_QPI_ENTER: assert property (
        lk.cs_rise && clean && opcode == OP_QPI_ENTER && !lk.hw_reset
        |=> quad_cmd_mode) else $error("four-line mode not entered");
    AST_MODE_END: assert property (
        lk.cs_rise && mode_exit && !lk.hw_reset |=> !cont_read)
        else $error("continuous read kept after end mode byte");
    AST_ONES_EXIT: assert property (
        $fell(cont_read) && !$past(lk.hw_reset) && !$past(lk.cs_rise)
        |-> $past(ones_cnt) + 4'h1 == $past(exit_len))
        else $error("continuous read left on wrong ones count");
    AST_CONT_ENTER: assert property (
        $rose(cont_read) |-> $past(state) == ST_MODE &&
        $past(sh_new) == MODE_CONT_ENTER)
        else $error("continuous read entered without A5h");
    AST_QE_GATE: assert property (
        state == ST_OPCODE && byte_done && lk.sclk_rise &&
        !quad_enable_flag && !quad_cmd_mode && !lk.hw_reset && !lk.cs_fall
        |=> state != ST_ADDR) else $error("quad read taken without enable");
    AST_WRSR_WEL: assert property (
        nv_write |-> $past(wel) && !wel && nv_write_data == sr)
        else $error("status written without write enable");
    AST_RESET_PAIR: assert property (
        soft_rst |-> arm && $past(lk.cs_rise, 2) == 1'b0)
        else $error("soft reset without reset enable");
    AST_ADDR4_EXIT: assert property (
        lk.cs_rise && clean && opcode == OP_ADDR4_EXIT |=> !addr4_mode)
        else $error("four-byte mode not left");
    AST_HW_RESET: assert property (
        lk.hw_reset |=> !addr4_mode && !cont_read && !quad_cmd_mode)
        else $error("hardware reset left a mode set");
    AST_SOFT_RESET: assert property (
        soft_rst |=> !cont_read && !quad_cmd_mode && !addr4_mode)
        else $error("soft reset left a mode set");
    AST_CONT_NO_OPCODE: assert property (
        lk.cs_fall && cont_read && !lk.hw_reset |=> state == ST_ADDR)
        else $error("continuous read frame expected an instruction");

    COV_CONT: cover property ($rose(cont_read));
    COV_ONES: cover property (ones_run && ones_cnt == 4'h7 ##1 !cont_read);
    COV_SOFT: cover property (soft_rst);
    COV_QPI: cover property ($rose(quad_cmd_mode));
endmodule // sfm_mode_ctrl

// ### include/sfm_pkg.sv
// Constants shared by the serial flash mode-control block
package sfm_pkg;
    // =========================================================
    // Instruction codes
    localparam logic [7:0] OP_WREN = 8'h06;
    localparam logic [7:0] OP_WRSR = 8'h01;
    localparam logic [7:0] OP_QPI_ENTER = 8'h35;
    localparam logic [7:0] OP_QPI_EXIT = 8'hf5;
    localparam logic [7:0] OP_RST_ENABLE = 8'h66;
    localparam logic [7:0] OP_RST = 8'h99;
    localparam logic [7:0] OP_ADDR4_EXIT = 8'he9;
    localparam logic [7:0] OP_QUAD_READ = 8'heb;
    // =========================================================
    // Mode byte values after a quad read address
    localparam logic [7:0] MODE_CONT_ENTER = 8'ha5;
    localparam logic [7:0] MODE_CONT_END = 8'h00;
    // =========================================================
    // Status register layout and reset value
    localparam int QE_BIT = 6;
    localparam int WEL_BIT = 1;
    localparam logic [7:0] SR_RESET = 8'h00;
    // =========================================================
    // Link sampling and frame counts
    localparam logic [3:0] LANES_ALL_ONES = 4'hf;
    localparam logic [3:0] ONES_EXIT_3B = 4'h8;
    localparam logic [3:0] ONES_EXIT_4B = 4'ha;
    localparam logic [2:0] ADDR_BYTES_3B = 3'h3;
    localparam logic [2:0] ADDR_BYTES_4B = 3'h4;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [6:0] PIN_IDLE = 7'h60;
    typedef enum logic [2:0] {
        ST_IDLE, ST_OPCODE, ST_ADDR, ST_MODE, ST_DATA, ST_SKIP
    } sfm_state_e;
endpackage

// ### include/sfm_link_if.sv
// Synchronised link events passed from the pin receiver to the core
interface sfm_link_if;
    logic sclk_rise;
    logic cs_fall;
    logic cs_rise;
    logic cs_active;
    logic hw_reset;
    logic [3:0] dq;
    modport rx (output sclk_rise, cs_fall, cs_rise, cs_active, hw_reset, dq);
    modport core (input sclk_rise, cs_fall, cs_rise, cs_active, hw_reset, dq);
endinterface

// ### verilog/sfm_link_rx.sv
// Pin synchroniser and edge finder for the serial flash link
module sfm_link_rx
    import sfm_pkg::*;
(
    input wire logic mclk,
    input wire logic resetn,
    input wire logic sclk_pin,
    input wire logic cs_n_pin,
    input wire logic [3:0] dq_pin,
    input wire logic hw_reset_n_pin,
    sfm_link_if.rx lk
);
    // =========================================================
    // Three-stage capture; a level is taken once stages 2 and 3 agree
    logic [6:0] s1;
    logic [6:0] s2;
    logic [6:0] s3;
    logic [6:0] filt;
    logic [6:0] prev;
    logic [6:0] next_filt;

    always_comb begin
        for (int i = 0; i < 7; i++) begin
            next_filt[i] = (s2[i] == s3[i]) ? s3[i] : filt[i];
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            s1 <= PIN_IDLE;
            s2 <= PIN_IDLE;
            s3 <= PIN_IDLE;
            filt <= PIN_IDLE;
            prev <= PIN_IDLE;
        end else begin
            s1 <= {hw_reset_n_pin, cs_n_pin, sclk_pin, dq_pin};
            s2 <= s1;
            s3 <= s2;
            filt <= next_filt;
            prev <= filt;
        end
    end

    // =========================================================
    // Events in the core clock domain
    assign lk.sclk_rise = filt[4] & ~prev[4];
    assign lk.cs_active = ~filt[5];
    assign lk.cs_fall = ~filt[5] & prev[5];
    assign lk.cs_rise = filt[5] & ~prev[5];
    assign lk.hw_reset = ~filt[6];
    assign lk.dq = filt[3:0];
endmodule // sfm_link_rx

// ### tb/sfm_host_model.sv
// Host-side serial flash controller model that drives the link pins
module sfm_host_model
    import sfm_pkg::*;
(
    input wire logic mclk,
    output logic sclk,
    output logic cs_n,
    output logic [3:0] dq,
    output logic hw_rst_n
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        dq = 4'h0;
        hw_rst_n = 1'b1;
    end

    // =========================================================
    // Pin timing
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask

    // Data moves with the falling phase, so it is steady across the rise
    task automatic nib(input logic [3:0] d);
        dq <= d;
        tick(4);
        sclk <= ~sclk;
        tick(4);
        sclk <= ~sclk;
    endtask

    task automatic start();
        cs_n <= 1'b0;
        tick(4);
    endtask

    // Released lines must not keep showing the last value
    task automatic stop();
        tick(4);
        cs_n <= 1'b1;
        dq <= ~dq;
        tick(10);
    endtask

    // =========================================================
    // Byte and frame helpers
    task automatic byte1(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            nib({4{b[i]}});
        end
    endtask

    task automatic byte4(input logic [7:0] b);
        nib(b[7:4]);
        nib(b[3:0]);
    endtask

    task automatic cmd(input logic [7:0] op, input logic q);
        start();
        if (q) begin
            byte4(op);
        end else begin
            byte1(op);
        end
        stop();
    endtask

    task automatic wrsr(input logic [7:0] d);
        start();
        byte1(OP_WRSR);
        byte1(d);
        stop();
    endtask

    // Quad read up to the mode byte; op=0 is a continuous-read frame
    task automatic head(input logic op, input logic q, input int n);
        start();
        if (op && q) begin
            byte4(OP_QUAD_READ);
        end else if (op) begin
            byte1(OP_QUAD_READ);
        end
        for (int i = 1; i <= n; i++) begin
            nib(4'(i));
        end
    endtask

    task automatic rd(input logic op, input logic q, input int n,
                      input logic [7:0] mode);
        head(op, q, n);
        byte4(mode);
        stop();
    endtask

    task automatic hw_pulse();
        hw_rst_n <= ~hw_rst_n;
        tick(8);
        hw_rst_n <= ~hw_rst_n;
        tick(8);
    endtask
endmodule // sfm_host_model

// ### tb/testbench.sv
// Self-checking bench for the serial flash mode-control block
`define SFM_CHK(a, e) begin n_tests++; if ((a) !== (e)) begin err_total++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end

module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    import sfm_pkg::*;

    localparam logic [7:0] ADDR4_ENTER = 8'hb7;
    logic mclk, resetn, sclk, cs_n, hw_rst_n, qe, qcmd, cont, a4, nvw;
    logic [3:0] dq;
    logic [7:0] status_reg, nv_data;
    // Stored status at first power-up: quad-enable set
    logic [7:0] nv_status_init = 8'h40;
    int err_total = 0;
    int n_tests = 0;
    int cyc = 0;
    int nv_cnt = 0;

    sfm_mode_ctrl #(.OP_ADDR4_ENTER(ADDR4_ENTER)) i_dut (.mclk(mclk),
        .resetn(resetn), .sclk_pin(sclk), .cs_n_pin(cs_n),
        .quad_data_lines(dq), .hw_reset_n_pin(hw_rst_n),
        .nv_status_init(nv_status_init), .status_reg(status_reg),
        .quad_enable_flag(qe), .quad_cmd_mode(qcmd), .cont_read(cont),
        .addr4_mode(a4), .nv_write(nvw), .nv_write_data(nv_data));
    sfm_host_model i_host (.mclk(mclk), .sclk(sclk), .cs_n(cs_n),
        .dq(dq), .hw_rst_n(hw_rst_n));

    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    // =========================================================
    // Non-volatile store and run limit
    always @(posedge mclk) begin
        cyc++;
        if (nvw === 1'b1) begin
            nv_cnt++;
            nv_status_init <= nv_data;
        end
        if (cyc == 30000) begin
            err_total++;
            summarize();
        end
    end

    task automatic summarize();
        $display("Checks %0d, mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic power_up();
        resetn <= 1'b0;
        i_host.tick(12);
        resetn <= 1'b1;
        i_host.tick(4);
    endtask

    // =========================================================
    // Scenarios
    task automatic t_reset();
        `SFM_CHK(status_reg, 8'h40)
        `SFM_CHK(qe, 1'b1)
        `SFM_CHK({qcmd, cont, a4}, 3'b000)
    endtask

    task automatic t_wrsr();
        i_host.wrsr(8'h00);
        `SFM_CHK(status_reg, 8'h40)
        i_host.cmd(OP_WREN, 1'b0);
        `SFM_CHK(status_reg[WEL_BIT], 1'b1)
        i_host.wrsr(8'h00);
        `SFM_CHK(nv_cnt, 1)
        `SFM_CHK(qe, 1'b0)
        // Without the flag the quad read must not arm continuous read
        i_host.rd(1'b1, 1'b0, 6, MODE_CONT_ENTER);
        `SFM_CHK(cont, 1'b0)
        i_host.cmd(OP_WREN, 1'b0);
        i_host.wrsr(8'h44);
        `SFM_CHK(status_reg, 8'h44)
        `SFM_CHK(nv_cnt, 2)
        `SFM_CHK(qe, 1'b1)
        power_up();
        `SFM_CHK(status_reg, 8'h44)
    endtask

    task automatic t_cont();
        i_host.rd(1'b1, 1'b0, 6, MODE_CONT_ENTER);
        `SFM_CHK(cont, 1'b1)
        i_host.rd(1'b0, 1'b0, 6, MODE_CONT_ENTER);
        `SFM_CHK(cont, 1'b1)
        i_host.head(1'b0, 1'b0, 6);
        i_host.byte4(MODE_CONT_END);
        `SFM_CHK(cont, 1'b1)
        i_host.stop();
        `SFM_CHK(cont, 1'b0)
    endtask

    task automatic ones_exit(input int n);
        i_host.start();
        repeat (n - 1) i_host.nib(LANES_ALL_ONES);
        // The last rise reaches the core a few clocks after the pin
        i_host.tick(2);
        `SFM_CHK(cont, 1'b1)
        i_host.nib(LANES_ALL_ONES);
        i_host.tick(2);
        `SFM_CHK(cont, 1'b0)
        i_host.stop();
    endtask

    task automatic t_ones();
        i_host.rd(1'b1, 1'b0, 6, MODE_CONT_ENTER);
        ones_exit(8);
        i_host.cmd(ADDR4_ENTER, 1'b0);
        `SFM_CHK(a4, 1'b1)
        i_host.rd(1'b1, 1'b0, 8, MODE_CONT_ENTER);
        ones_exit(10);
        i_host.cmd(OP_ADDR4_EXIT, 1'b0);
        `SFM_CHK(a4, 1'b0)
    endtask

    task automatic t_qpi();
        i_host.cmd(OP_QPI_ENTER, 1'b0);
        `SFM_CHK(qcmd, 1'b1)
        i_host.rd(1'b1, 1'b1, 6, MODE_CONT_ENTER);
        `SFM_CHK(cont, 1'b1)
        i_host.rd(1'b0, 1'b1, 6, MODE_CONT_END);
        `SFM_CHK(cont, 1'b0)
        i_host.cmd(OP_QPI_EXIT, 1'b1);
        `SFM_CHK(qcmd, 1'b0)
        i_host.cmd(OP_WREN, 1'b0);
        `SFM_CHK(status_reg[WEL_BIT], 1'b1)
    endtask

    task automatic t_soft();
        i_host.cmd(ADDR4_ENTER, 1'b0);
        i_host.cmd(OP_QPI_ENTER, 1'b0);
        i_host.cmd(OP_RST, 1'b1);
        `SFM_CHK(qcmd, 1'b1)
        i_host.cmd(OP_RST_ENABLE, 1'b1);
        i_host.cmd(OP_WREN, 1'b1);
        i_host.cmd(OP_RST, 1'b1);
        `SFM_CHK(qcmd, 1'b1)
        i_host.cmd(OP_RST_ENABLE, 1'b1);
        i_host.cmd(OP_RST, 1'b1);
        `SFM_CHK({qcmd, a4}, 2'b00)
        `SFM_CHK(status_reg, 8'h44)
    endtask

    task automatic t_hw();
        i_host.cmd(ADDR4_ENTER, 1'b0);
        i_host.cmd(OP_QPI_ENTER, 1'b0);
        i_host.rd(1'b1, 1'b1, 8, MODE_CONT_ENTER);
        `SFM_CHK(cont, 1'b1)
        i_host.hw_pulse();
        `SFM_CHK(a4, 1'b0)
        `SFM_CHK({qcmd, cont}, 2'b00)
        `SFM_CHK(status_reg, 8'h44)
        // Single-line instruction and three address bytes work again
        i_host.rd(1'b1, 1'b0, 6, MODE_CONT_ENTER);
        `SFM_CHK(cont, 1'b1)
        ones_exit(8);
    endtask

    // =========================================================
    // Main sequence
    initial begin
        resetn = 1'b0;
        i_host.tick(12);
        resetn <= 1'b1;
        i_host.tick(4);
        t_reset();
        t_wrsr();
        t_cont();
        t_ones();
        t_qpi();
        t_soft();
        t_hw();
        summarize();
    end
endmodule // testbench
